// *** verilog/can_xcvr_ctrl.sv ***
/*
 * Mode, receive routing and fail-safe control of a CAN transceiver.
 * Assumes bus state, supply and thermal comparators arrive as
 * asynchronous levels; pull-ups are analog, default levels apply.
 */
`timescale 1ns/1ps
`default_nettype none
`include "can_xcvr_defs.svh"

module can_xcvr_ctrl
    import can_xcvr_pkg::*;
#(
    parameter int TXD_TO_CYCLES = `TXD_TO_CYC,
    parameter int BUS_TO_CYCLES = `BUS_TO_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Controller side
    input wire logic i_txd,
    input wire logic i_mode_select_in,
    output logic o_rxd,
    // Bus comparators: 1 means dominant
    input wire logic i_bus_dom,
    input wire logic i_lp_bus_dom,
    // Supply and thermal monitors
    input wire logic i_main_supply_uv,
    input wire logic i_io_uv,
    input wire logic i_thermal_shutdown_level,
    // Front end controls
    output afe_ctl_s o_afe,
    output mode_e o_mode
);

    logic [1:0] rst_sync_r;
    logic rst_n;
    logic [1:0] s1_r [6];
    logic txd, mode_sel, bdom, lpdom, vuv, iouv, hot;
    mode_e mode_r, mode_nxt;
    logic [`TMR_W-1:0] txd_cnt_r;
    logic txd_to_r;
    logic [`TMR_W-1:0] bus_cnt_r;
    logic bus_to_r;
    logic lpdom_d_r;
    logic [`TMR_W-1:0] flt_cnt_r;
    logic flt_r;
    logic hot_lock_r;
    logic rxd_nxt;
    afe_ctl_s afe_nxt;

    localparam logic [`TMR_W-1:0] WAKE_TC = `TMR_W'(`WAKE_FLTR_CYC);
    localparam logic [`TMR_W-1:0] TXD_TC = `TMR_W'(TXD_TO_CYCLES);
    localparam logic [`TMR_W-1:0] BUS_TC = `TMR_W'(BUS_TO_CYCLES);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // Pin synchronisers, txd and mode select reset to their pulled-up levels, the others reset low
    wire [5:0] pins = {i_txd, i_mode_select_in, i_bus_dom, i_lp_bus_dom,
                       i_main_supply_uv, i_io_uv};
    for (genvar g = 0; g < 6; g++) begin : g_sync
        always_ff @(posedge i_clk or negedge rst_n) begin
            if (!rst_n) begin
                s1_r[g] <= (g >= 4) ? 2'h3 : 2'h0;
            end else begin
                s1_r[g] <= {s1_r[g][0], pins[g]};
            end
        end
    end
    logic [1:0] hot_s_r;
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            hot_s_r <= 2'h0;
        end else begin
            hot_s_r <= {hot_s_r[0], i_thermal_shutdown_level};
        end
    end
    assign txd = s1_r[5][1];
    assign mode_sel = s1_r[4][1];
    assign bdom = s1_r[3][1];
    assign lpdom = s1_r[2][1];
    assign vuv = s1_r[1][1];
    assign iouv = s1_r[0][1];
    assign hot = hot_s_r[1];

    // Mode selection
    always_comb begin
        if (iouv) begin
            mode_nxt = MODE_OFF;
        end else if (vuv) begin
            mode_nxt = MODE_STANDBY;
        end else if (mode_sel) begin
            mode_nxt = MODE_STANDBY;
        end else begin
            mode_nxt = MODE_NORMAL;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= MODE_STANDBY;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            txd_cnt_r <= '0;
            txd_to_r <= 1'b0;
        end else if (txd) begin
            txd_cnt_r <= '0;
            txd_to_r <= 1'b0;
        end else if (txd_cnt_r < TXD_TC) begin
            txd_cnt_r <= txd_cnt_r + `TMR_W'(1);
        end else begin
            txd_to_r <= 1'b1;
        end
    end

    // Thermal lock until cool and transmit recessive
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            hot_lock_r <= 1'b0;
        end else if (hot) begin
            hot_lock_r <= 1'b1;
        end else if (txd) begin
            hot_lock_r <= 1'b0;
        end
    end

    // Wake filter: pass states lasting beyond filter time
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            lpdom_d_r <= 1'b0;
            flt_cnt_r <= '0;
            flt_r <= 1'b0;
        end else begin
            lpdom_d_r <= lpdom;
            if (lpdom != lpdom_d_r || lpdom == flt_r) begin
                flt_cnt_r <= '0;
            end else if (flt_cnt_r < WAKE_TC) begin
                flt_cnt_r <= flt_cnt_r + `TMR_W'(1);
            end else begin
                flt_r <= lpdom;
            end
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_cnt_r <= '0;
            bus_to_r <= 1'b0;
        end else if (mode_r != MODE_STANDBY) begin
            bus_cnt_r <= '0;
            bus_to_r <= 1'b0;
        end else if (!lpdom) begin
            bus_cnt_r <= '0;
            // Forced high holds until the filter passes recessive
            if (!flt_r) begin
                bus_to_r <= 1'b0;
            end
        end else if (bus_cnt_r < BUS_TC) begin
            bus_cnt_r <= bus_cnt_r + `TMR_W'(1);
        end else begin
            bus_to_r <= 1'b1;
        end
    end

    always_comb begin
        afe_nxt = '0;
        rxd_nxt = 1'b1;
        unique case (mode_nxt)
            MODE_NORMAL: begin
                afe_nxt.tx_drive_en = !txd_to_r && !hot_lock_r && !hot;
                afe_nxt.rx_normal_en = 1'b1;
                afe_nxt.bias_rec = 1'b1;
                afe_nxt.split_en = 1'b1;
                rxd_nxt = !bdom;
            end
            MODE_STANDBY: begin
                afe_nxt.lp_rx_en = 1'b1;
                afe_nxt.bias_gnd = 1'b1;
                rxd_nxt = !(flt_r && !bus_to_r);
            end
            MODE_OFF: begin
                rxd_nxt = 1'b1;
            end
            default: begin
                rxd_nxt = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_rxd <= 1'b1;
            // Reset presents Standby, matching the pulled-up mode select
            o_afe <= '{lp_rx_en: 1'b1, bias_gnd: 1'b1, default: 1'b0};
            o_mode <= MODE_STANDBY;
        end else begin
            o_rxd <= rxd_nxt;
            o_afe <= afe_nxt;
            o_mode <= mode_nxt;
        end
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (!rst_n);

    sequence s_txd_stuck;
        !txd [*8];
    endsequence

    a_normal_select: assert property (
        (!mode_sel && !vuv && !iouv) |=> o_mode == MODE_NORMAL)
        else $error("mode select low did not give Normal");
    a_standby_select: assert property (
        (mode_sel && !iouv) |=> o_mode == MODE_STANDBY && !o_afe.tx_drive_en)
        else $error("mode select high did not give Standby");
    a_normal_rx: assert property (
        (mode_nxt == MODE_NORMAL) |=> o_rxd == !$past(bdom))
        else $error("receive output not following bus");
    a_standby_afe: assert property (
        (o_mode == MODE_STANDBY) |-> o_afe.lp_rx_en && !o_afe.rx_normal_en)
        else $error("standby receiver setting wrong");
    a_standby_bias: assert property (
        (o_mode == MODE_STANDBY) |-> o_afe.bias_gnd && !o_afe.bias_rec)
        else $error("standby bias wrong");
    a_wake_nolatch: assert property (
        (o_mode == MODE_STANDBY && !lpdom) [*3] |=> ##[0:200] o_rxd
        || o_mode != MODE_STANDBY)
        else $error("dominant state latched");
    a_wake_filter: assert property (
        $rose(flt_r) |-> flt_cnt_r == WAKE_TC)
        else $error("wake filter passed a short state");
    a_wake_stay: assert property (
        (o_mode == MODE_STANDBY && !o_rxd && mode_sel) |=> o_mode == MODE_STANDBY)
        else $error("wake request left Standby");
    a_txd_release: assert property (
        txd_to_r |=> !o_afe.tx_drive_en)
        else $error("transmitter not released after time-out");
    a_txd_clear: assert property (
        s_txd_stuck ##1 txd |=> txd_cnt_r == '0)
        else $error("transmit timer not cleared");
    a_bus_to: assert property (
        (bus_to_r && o_mode == MODE_STANDBY && mode_nxt == MODE_STANDBY)
        |=> o_rxd)
        else $error("receive output not forced high");
    a_bus_clear: assert property (
        $fell(lpdom) |=> bus_cnt_r == '0)
        else $error("bus timer not cleared");
    a_uv_standby: assert property (
        (vuv && !iouv) |=> o_mode == MODE_STANDBY)
        else $error("undervoltage did not force Standby");
    a_io_off: assert property (
        iouv |=> o_afe == '0)
        else $error("I/O undervoltage did not switch off");
    a_hot_off: assert property (
        (hot_lock_r && !txd) |=> !o_afe.tx_drive_en)
        else $error("drivers re-enabled while locked");
    a_split_normal: assert property (
        o_afe.split_en |-> o_mode == MODE_NORMAL)
        else $error("split driven outside Normal");

endmodule : can_xcvr_ctrl
`default_nettype wire

// *** verilog/can_xcvr_defs.svh ***
/*
 * Timing constants for the transceiver control logic.
 * Assumes a 100 MHz core clock; counts derive from times in ns.
 */
`ifndef CAN_XCVR_DEFS_SVH
`define CAN_XCVR_DEFS_SVH

`define CLK_PERIOD_NS 10
// Wake filter time, least, in ns
`define WAKE_FLTR_NS 1000
`define WAKE_FLTR_CYC ((`WAKE_FLTR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Transmit dominant time-out, in ns
`define TXD_TO_NS 1000000
`define TXD_TO_CYC (`TXD_TO_NS / `CLK_PERIOD_NS)
// Bus dominant time-out, in ns
`define BUS_TO_NS 1000000
`define BUS_TO_CYC (`BUS_TO_NS / `CLK_PERIOD_NS)
`define TMR_W 20

`endif

// *** verilog/can_xcvr_pkg.sv ***
/*
 * Types for the transceiver control logic.
 * Assumes can_xcvr_defs.svh supplies the numeric constants.
 */
package can_xcvr_pkg;

    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_STANDBY = 2'b01,
        MODE_NORMAL = 2'b10
    } mode_e;

    // Analog front end controls
    typedef struct packed {
        logic tx_drive_en;
        logic rx_normal_en;
        logic lp_rx_en;
        logic bias_gnd;
        logic bias_rec;
        logic split_en;
    } afe_ctl_s;

endpackage : can_xcvr_pkg

// *** verif/can_ctl_model.sv ***
/*
 * Controller-side model: drives transmit data and mode select.
 * Assumes the bench clock; every change lands on a falling edge.
 */
`timescale 1ns/1ps
`default_nettype none
module can_ctl_model (
    // Clock
    input wire logic i_clk,
    // Controller pins
    output logic o_txd,
    output logic o_mode_select_in
);
    initial begin
        o_txd = 1'b1;
        o_mode_select_in = 1'b1;
    end

    task automatic set_mode(input logic normal);
        @(negedge i_clk);
        o_mode_select_in = !normal;
        if (!normal) begin
            o_txd = 1'b1;
        end
    endtask : set_mode

    task automatic set_txd(input logic level);
        @(negedge i_clk);
        o_txd = level;
    endtask : set_txd

    // dominant runs kept well below the time-out
    task automatic send_frame(input int bits, input int bit_cyc);
        int run;
        run = 0;
        for (int b = 0; b < bits; b++) begin
            @(negedge i_clk);
            o_txd = (run == 5) ? 1'b1 : 1'($urandom);
            run = o_txd ? 0 : run + 1;
            repeat (bit_cyc - 1) @(negedge i_clk);
        end
        @(negedge i_clk);
        o_txd = 1'b1;
    endtask : send_frame
endmodule : can_ctl_model
`default_nettype wire

// *** verif/test_can_xcvr_ctrl.sv ***
/*
 * Self-checking bench for the transceiver control logic.
 * Assumes shortened time-outs; inputs change on falling edges.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, what) begin compares++; if ((got) !== (exp)) begin err_total++; \
    $display("unexpected at %0t: %s", $time, what); end end
module test_can_xcvr_ctrl;
    import can_xcvr_pkg::*;
    localparam int TXD_TO = 50;
    localparam int BUS_TO = 300;
    localparam int FLT = 100;
    localparam afe_ctl_s NRM = 6'h33;
    localparam afe_ctl_s NTX = 6'h13;
    localparam afe_ctl_s SBY = 6'h0C;
    localparam afe_ctl_s OFF = 6'h00;
    typedef struct packed {logic rxd; afe_ctl_s afe; mode_e mode;} note_s;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic bus_dom = 1'b0;
    logic lp_dom = 1'b0;
    logic main_uv = 1'b0;
    logic io_uv = 1'b0;
    logic hot = 1'b0;
    logic txd;
    logic mode_sel;
    logic o_rxd;
    afe_ctl_s o_afe;
    mode_e o_mode;
    note_s notes[$];
    event sample_ev;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;

    always #5 i_clk = ~i_clk;

    can_ctl_model ctl (.i_clk(i_clk), .o_txd(txd), .o_mode_select_in(mode_sel));

    can_xcvr_ctrl #(.TXD_TO_CYCLES(TXD_TO), .BUS_TO_CYCLES(BUS_TO)) dut (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_txd(txd),
        .i_mode_select_in(mode_sel),
        .o_rxd(o_rxd),
        .i_bus_dom(bus_dom),
        .i_lp_bus_dom(lp_dom),
        .i_main_supply_uv(main_uv),
        .i_io_uv(io_uv),
        .i_thermal_shutdown_level(hot),
        .o_afe(o_afe),
        .o_mode(o_mode)
    );

    task automatic end_of_test();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    task automatic step(input int n);
        repeat (n) @(negedge i_clk);
    endtask : step

    task automatic expect_now(input logic rxd, input afe_ctl_s afe, input mode_e mode);
        notes.push_back({rxd, afe, mode});
        -> sample_ev;
    endtask : expect_now

    always @(sample_ev) begin : monitor
        note_s n;
        n = notes.pop_front();
        `CHK({o_rxd, o_afe, o_mode}, n, "outputs differ from note")
    end

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            end_of_test();
        end
    end

    initial begin : main
        void'($urandom(32'hD08C84C5));
        step(2);
        expect_now(1'b1, SBY, MODE_STANDBY);
        step(3);
        i_rst_n = 1'b1;
        step(6);
        expect_now(1'b1, SBY, MODE_STANDBY);
        ctl.set_mode(1'b1);
        step(5);
        expect_now(1'b1, NRM, MODE_NORMAL);
        for (int k = 0; k < 8; k++) begin
            bus_dom = 1'($urandom);
            lp_dom = 1'($urandom);
            step(5);
            expect_now(!bus_dom, NRM, MODE_NORMAL);
        end
        bus_dom = 1'b0;
        lp_dom = 1'b0;
        ctl.send_frame(16, 4);
        step(5);
        expect_now(1'b1, NRM, MODE_NORMAL);
        ctl.set_txd(1'b0);
        step(TXD_TO - 10);
        expect_now(1'b1, NRM, MODE_NORMAL);
        step(20);
        expect_now(1'b1, NTX, MODE_NORMAL);
        ctl.set_txd(1'b1);
        step(5);
        expect_now(1'b1, NRM, MODE_NORMAL);
        ctl.set_txd(1'b0);
        step(TXD_TO - 10);
        expect_now(1'b1, NRM, MODE_NORMAL);
        hot = 1'b1;
        step(5);
        expect_now(1'b1, NTX, MODE_NORMAL);
        hot = 1'b0;
        step(5);
        expect_now(1'b1, NTX, MODE_NORMAL);
        ctl.set_txd(1'b1);
        step(5);
        expect_now(1'b1, NRM, MODE_NORMAL);
        main_uv = 1'b1;
        step(5);
        expect_now(1'b1, SBY, MODE_STANDBY);
        main_uv = 1'b0;
        io_uv = 1'b1;
        step(5);
        expect_now(1'b1, OFF, MODE_OFF);
        io_uv = 1'b0;
        step(5);
        expect_now(1'b1, NRM, MODE_NORMAL);
        ctl.set_mode(1'b0);
        bus_dom = 1'b1;
        step(5);
        expect_now(1'b1, SBY, MODE_STANDBY);
        bus_dom = 1'b0;
        lp_dom = 1'b1;
        step(FLT / 2);
        lp_dom = 1'b0;
        step(10);
        expect_now(1'b1, SBY, MODE_STANDBY);
        step(FLT);
        lp_dom = 1'b1;
        step(FLT + 10);
        expect_now(1'b0, SBY, MODE_STANDBY);
        step(BUS_TO);
        expect_now(1'b1, SBY, MODE_STANDBY);
        lp_dom = 1'b0;
        step(FLT + 10);
        lp_dom = 1'b1;
        step(FLT + 10);
        expect_now(1'b0, SBY, MODE_STANDBY);
        lp_dom = 1'b0;
        step(FLT + 10);
        expect_now(1'b1, SBY, MODE_STANDBY);
        step(2);
        end_of_test();
    end
endmodule : test_can_xcvr_ctrl
`default_nettype wire
